// [core/vic_pkg.sv]
// package: register map, field layout and sizes of the vectored interrupt controller
package vic_pkg;
    // ========================================
    // sizes
    localparam int NUM_SRC = 32;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int PRIO_W = 3;
    localparam int STACK_DEPTH = 8;
    localparam int DEPTH_W = 4;
    // ========================================
    // register offsets (byte addresses)
    localparam logic [11:0] OFS_MODE_BASE = 12'h000;
    localparam logic [11:0] OFS_VECT_BASE = 12'h080;
    localparam logic [11:0] OFS_NORMAL_VECTOR_READ = 12'h100;
    localparam logic [11:0] OFS_FAST_VECTOR_READ = 12'h104;
    localparam logic [11:0] OFS_CURRENT_SOURCE_NUMBER = 12'h108;
    localparam logic [11:0] OFS_PENDING_BITS = 12'h10c;
    localparam logic [11:0] OFS_ENABLED_BITS = 12'h110;
    localparam logic [11:0] OFS_CORE_LINE_STATUS = 12'h114;
    localparam logic [11:0] OFS_ENABLE_COMMAND = 12'h120;
    localparam logic [11:0] OFS_DISABLE_COMMAND = 12'h124;
    localparam logic [11:0] OFS_CLEAR_PENDING_COMMAND = 12'h128;
    localparam logic [11:0] OFS_SET_PENDING_COMMAND = 12'h12c;
    localparam logic [11:0] OFS_END_OF_SERVICE_COMMAND = 12'h130;
    localparam logic [11:0] OFS_SPURIOUS_VECTOR = 12'h134;
    localparam logic [11:0] OFS_DEBUG_CONTROL = 12'h138;
    localparam logic [11:0] OFS_FAST_FORCE_ENABLE_COMMAND = 12'h140;
    localparam logic [11:0] OFS_FAST_FORCE_DISABLE_COMMAND = 12'h144;
    localparam logic [11:0] OFS_FAST_FORCE_STATUS = 12'h148;
    // ========================================
    // field positions
    localparam int FLD_PRIO_LSB = 0;
    localparam int FLD_TYPE_LSB = 5;
    localparam int FLD_PROTECTION_ENABLE = 0;
    localparam int FLD_GLOBAL_LINE_MASK = 1;
    localparam int FLD_FAST_LINE_STATUS = 0;
    localparam int FLD_NORMAL_LINE_STATUS = 1;
    localparam int SRC_FAST_REQUEST = 0;
    localparam int SRCTYPE_EDGE_BIT = 0;
    // ========================================
    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [2:0] RST_PRIO = 3'h0;
    localparam logic [1:0] RST_TYPE = 2'h0;
    localparam logic [4:0] RST_ID = 5'h00;
    localparam logic [3:0] RST_DEPTH = 4'h0;
    localparam logic [1:0] RST_DEBUG = 2'h0;
endpackage : vic_pkg

// [core/vic_ctrl.sv]
// vectored interrupt controller: status/command registers, priority stack, request lines
`timescale 1ns/100ps
`default_nettype none
module vic_ctrl
    import vic_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [DATA_W-1:0] regRdData,
    // interrupt sources, asynchronous, active high
    input wire logic [NUM_SRC-1:0] srcReq,
    // processor request lines, active low
    output logic fastReqOutN,
    output logic normalReqOutN
);

    // ========================================
    // state
    logic [NUM_SRC-1:0] srcMeta_q;
    logic [NUM_SRC-1:0] srcSync_q;
    logic [NUM_SRC-1:0] srcPrev_q;
    logic [NUM_SRC-1:0] pendLatch_q;
    logic [NUM_SRC-1:0] pendLatch_d;
    logic [NUM_SRC-1:0] enabled_q;
    logic [NUM_SRC-1:0] fastForce_q;
    logic [PRIO_W-1:0] srcPrio_q [NUM_SRC];
    logic [1:0] srcType_q [NUM_SRC];
    logic [DATA_W-1:0] srcVect_q [NUM_SRC];
    logic [DATA_W-1:0] spurious_q;
    logic [1:0] debug_q;
    logic [4:0] stkId_q [STACK_DEPTH];
    logic [PRIO_W-1:0] stkPrio_q [STACK_DEPTH];
    logic [DEPTH_W-1:0] depth_q;
    logic [DATA_W-1:0] regRdData_q;
    logic fastReqOutN_q;
    logic normalReqOutN_q;

    // ========================================
    // combinational terms
    logic [NUM_SRC-1:0] edgeHit;
    logic [NUM_SRC-1:0] isEdge;
    logic [NUM_SRC-1:0] pending;
    logic [NUM_SRC-1:0] fastMap;
    logic candValid;
    logic [4:0] candId;
    logic [PRIO_W-1:0] candPrio;
    logic [4:0] curId;
    logic [PRIO_W-1:0] curPrio;
    logic wrHit;
    logic enterSvc;
    logic endSvc;
    logic fastRead;
    logic fastActive;
    logic normalActive;
    logic protect;
    logic lineMask;

    assign protect = debug_q[FLD_PROTECTION_ENABLE];
    assign lineMask = debug_q[FLD_GLOBAL_LINE_MASK];

    // address match used by every register write and strobe decode; the read mux decodes by range and case
    function automatic logic addrIs(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
        addrIs = (a == ofs);
    endfunction : addrIs

    // ========================================
    // source synchroniser and edge detect
    // sources are asynchronous, so two flops before any logic looks at them
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            srcMeta_q <= RST_WORD;
            srcSync_q <= RST_WORD;
            srcPrev_q <= RST_WORD;
        end else begin
            srcMeta_q <= srcReq;
            srcSync_q <= srcMeta_q;
            srcPrev_q <= srcSync_q;
        end
    end

    // per-source type decode and pending view
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : gSrc
            assign isEdge[g] = srcType_q[g][SRCTYPE_EDGE_BIT];
            assign edgeHit[g] = isEdge[g] & srcSync_q[g] & ~srcPrev_q[g];
            // pending view
            // level sources follow the line, latched bits add software triggers
            assign pending[g] = pendLatch_q[g] | (~isEdge[g] & srcSync_q[g]);
        end
    endgenerate

    // fast map: source 0 always, others only when fast forcing is on
    // forced sources routed
    assign fastMap = {fastForce_q[NUM_SRC-1:1], 1'b1};

    // ========================================
    // current level from the top of the priority stack
    always_comb begin
        curId = RST_ID;
        curPrio = RST_PRIO;
        if (depth_q != RST_DEPTH) begin
            curId = stkId_q[depth_q[2:0] - 3'h1];
            curPrio = stkPrio_q[depth_q[2:0] - 3'h1];
        end
    end

    // ========================================
    // candidate: highest priority enabled pending normal source
    // priority selects current
    // ties go to the lowest source number; must beat the level in service
    // fast-mapped sources never compete here, they belong to the other line
    always_comb begin
        candValid = 1'b0;
        candId = RST_ID;
        candPrio = RST_PRIO;
        for (int i = 1; i < NUM_SRC; i++) begin
            if (pending[i] && enabled_q[i] && !fastMap[i] &&
                (!candValid || srcPrio_q[i] > candPrio)) begin
                candValid = 1'b1;
                candId = 5'(i);
                candPrio = srcPrio_q[i];
            end
        end
        // nesting only for strictly higher priority; a full stack holds off
        if (depth_q == 4'(STACK_DEPTH)) begin
            candValid = 1'b0;
        end else if (depth_q != RST_DEPTH && candPrio <= curPrio) begin
            candValid = 1'b0;
        end
    end

    assign fastActive = |(pending & enabled_q & fastMap);
    assign normalActive = candValid;

    // ========================================
    // bus strobes and side effects
    assign wrHit = regWrStb;
    // protected normal vector read has no effect
    // in protection mode a debugger read of the normal vector is harmless; software writes the register instead
    assign enterSvc = candValid && addrIs(regAddr, OFS_NORMAL_VECTOR_READ) &&
                      ((regRdStb && !protect) || (regWrStb && protect));
    assign endSvc = regWrStb && addrIs(regAddr, OFS_END_OF_SERVICE_COMMAND);
    assign fastRead = regRdStb && addrIs(regAddr, OFS_FAST_VECTOR_READ) &&
                      pending[SRC_FAST_REQUEST] && enabled_q[SRC_FAST_REQUEST];

    // ========================================
    // pending latch: commands, service and edges
    // clears go first and sets last, so a set or an edge in the same cycle wins
    always_comb begin
        pendLatch_d = pendLatch_q;
        if (wrHit && addrIs(regAddr, OFS_CLEAR_PENDING_COMMAND)) begin
            pendLatch_d = pendLatch_d & ~regWrData;
        end
        if (enterSvc) begin
            pendLatch_d[candId] = 1'b0;
        end
        if (fastRead) begin
            pendLatch_d[SRC_FAST_REQUEST] = 1'b0;
        end
        if (wrHit && addrIs(regAddr, OFS_SET_PENDING_COMMAND)) begin
            pendLatch_d = pendLatch_d | regWrData;
        end
        // a hardware edge in the clearing cycle is never lost
        pendLatch_d = pendLatch_d | edgeHit;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pendLatch_q <= RST_WORD;
        end else begin
            pendLatch_q <= pendLatch_d;
        end
    end

    // ========================================
    // mask register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            enabled_q <= RST_WORD;
        end else if (wrHit && addrIs(regAddr, OFS_ENABLE_COMMAND)) begin
            enabled_q <= enabled_q | regWrData;
        end else if (wrHit && addrIs(regAddr, OFS_DISABLE_COMMAND)) begin
            enabled_q <= enabled_q & ~regWrData;
        end
    end

    // ========================================
    // fast forcing; bit 0 stays zero as source 0 is always fast
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            fastForce_q <= RST_WORD;
        end else if (wrHit && addrIs(regAddr, OFS_FAST_FORCE_ENABLE_COMMAND)) begin
            fastForce_q <= (fastForce_q | regWrData) & ~32'h0000_0001;
        end else if (wrHit && addrIs(regAddr, OFS_FAST_FORCE_DISABLE_COMMAND)) begin
            fastForce_q <= fastForce_q & ~regWrData;
        end
    end

    // ========================================
    // per-source mode and vector registers
    // a write that matches no mapped word changes nothing
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                srcPrio_q[i] <= RST_PRIO;
                srcType_q[i] <= RST_TYPE;
                srcVect_q[i] <= RST_WORD;
            end
        end else if (regWrStb) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                if (addrIs(regAddr, OFS_MODE_BASE + 12'(i * 4))) begin
                    srcPrio_q[i] <= regWrData[FLD_PRIO_LSB +: PRIO_W];
                    srcType_q[i] <= regWrData[FLD_TYPE_LSB +: 2];
                end
                if (addrIs(regAddr, OFS_VECT_BASE + 12'(i * 4))) begin
                    srcVect_q[i] <= regWrData;
                end
            end
        end
    end

    // ========================================
    // spurious vector and debug control
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            spurious_q <= RST_WORD;
            debug_q <= RST_DEBUG;
        end else if (regWrStb) begin
            if (addrIs(regAddr, OFS_SPURIOUS_VECTOR)) begin
                spurious_q <= regWrData;
            end
            if (addrIs(regAddr, OFS_DEBUG_CONTROL)) begin
                debug_q <= regWrData[1:0];
            end
        end
    end

    // ========================================
    // priority stack
    // end-of-service pops level
    // a lower pending source may raise the line again once the level drops
    // eight levels at most; a deeper request waits until a level is released
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            depth_q <= RST_DEPTH;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stkId_q[i] <= RST_ID;
                stkPrio_q[i] <= RST_PRIO;
            end
        end else if (enterSvc) begin
            stkId_q[depth_q[2:0]] <= candId;
            stkPrio_q[depth_q[2:0]] <= candPrio;
            depth_q <= depth_q + 4'h1;
        end else if (endSvc && depth_q != RST_DEPTH) begin
            depth_q <= depth_q - 4'h1;
        end
    end

    // ========================================
    // request lines, registered, active low
    // registering the lines keeps decode glitches off the core at one cycle of latency
    // global line mask
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            fastReqOutN_q <= 1'b1;
            normalReqOutN_q <= 1'b1;
        end else begin
            fastReqOutN_q <= ~(fastActive & ~lineMask);
            normalReqOutN_q <= ~(normalActive & ~lineMask);
        end
    end

    // ========================================
    // read data, loaded in the cycle after the strobe and held until the next read
    // mode words read back only the priority and type fields
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            regRdData_q <= RST_WORD;
        end else if (regRdStb) begin
            regRdData_q <= RST_WORD; // unmapped reads return zero
            if (regAddr < OFS_VECT_BASE) begin
                regRdData_q[FLD_PRIO_LSB +: PRIO_W] <= srcPrio_q[regAddr[6:2]];
                regRdData_q[FLD_TYPE_LSB +: 2] <= srcType_q[regAddr[6:2]];
            end else if (regAddr < OFS_NORMAL_VECTOR_READ) begin
                regRdData_q <= srcVect_q[regAddr[6:2]];
            end else begin
                case (regAddr)
                    OFS_NORMAL_VECTOR_READ: begin
                        regRdData_q <= candValid ? srcVect_q[candId] : spurious_q;
                    end
                    OFS_FAST_VECTOR_READ: begin
                        regRdData_q <= fastActive ? srcVect_q[SRC_FAST_REQUEST] : spurious_q;
                    end
                    OFS_CURRENT_SOURCE_NUMBER: begin
                        regRdData_q[4:0] <= curId;
                    end
                    OFS_PENDING_BITS: begin
                        regRdData_q <= pending;
                    end
                    OFS_ENABLED_BITS: begin
                        regRdData_q <= enabled_q;
                    end
                    OFS_CORE_LINE_STATUS: begin
                        regRdData_q[FLD_FAST_LINE_STATUS] <= ~fastReqOutN_q;
                        regRdData_q[FLD_NORMAL_LINE_STATUS] <= ~normalReqOutN_q;
                    end
                    OFS_SPURIOUS_VECTOR: begin
                        regRdData_q <= spurious_q;
                    end
                    OFS_DEBUG_CONTROL: begin
                        regRdData_q[1:0] <= debug_q;
                    end
                    OFS_FAST_FORCE_STATUS: begin
                        regRdData_q <= fastForce_q;
                    end
                    default: begin
                        regRdData_q <= RST_WORD;
                    end
                endcase
            end
        end
    end

    assign regRdData = regRdData_q;
    assign fastReqOutN = fastReqOutN_q;
    assign normalReqOutN = normalReqOutN_q;

endmodule : vic_ctrl
`default_nettype wire

// [verification/vic_ctrl_assertions.sv]
// checker: register port and request line properties of the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module vic_ctrl_assertions
    import vic_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    input wire logic [DATA_W-1:0] regRdData,
    // sources and request lines
    input wire logic [NUM_SRC-1:0] srcReq,
    input wire logic fastReqOutN,
    input wire logic normalReqOutN
);
    logic [31:0] maskQ;
    logic [31:0] ffQ;
    logic [31:0] spuQ;
    logic [1:0] dbgQ;
    // ========================================
    // shadow state, rebuilt from writes only so it never copies the design
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            maskQ <= 32'h0;
            ffQ <= 32'h0;
            spuQ <= 32'h0;
            dbgQ <= 2'h0;
        end else if (regWrStb) begin
            if (regAddr == OFS_ENABLE_COMMAND) maskQ <= maskQ | regWrData;
            if (regAddr == OFS_DISABLE_COMMAND) maskQ <= maskQ & ~regWrData;
            if (regAddr == OFS_FAST_FORCE_ENABLE_COMMAND) ffQ <= ffQ | {regWrData[31:1], 1'b0};
            if (regAddr == OFS_FAST_FORCE_DISABLE_COMMAND) ffQ <= ffQ & ~regWrData;
            if (regAddr == OFS_SPURIOUS_VECTOR) spuQ <= regWrData;
            if (regAddr == OFS_DEBUG_CONTROL) dbgQ <= regWrData[1:0];
        end
    end
    // ========================================
    // properties
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    a_id_upper_zero:
        assert property (regRdStb && regAddr == OFS_CURRENT_SOURCE_NUMBER |=> regRdData[31:5] == 27'h0)
        else $error("source number upper bits not zero");
    a_line_status:
        assert property (regRdStb && regAddr == OFS_CORE_LINE_STATUS |=>
            regRdData == {30'h0, !$past(normalReqOutN), !$past(fastReqOutN)})
        else $error("core status does not match lines");
    a_mask_track:
        assert property (regRdStb && regAddr == OFS_ENABLED_BITS |=> regRdData == $past(maskQ))
        else $error("mask differs from enable and disable history");
    a_force_track:
        assert property (regRdStb && regAddr == OFS_FAST_FORCE_STATUS |=> regRdData == $past(ffQ))
        else $error("fast force status differs from commands");
    a_spurious_keep:
        assert property (regRdStb && regAddr == OFS_SPURIOUS_VECTOR |=> regRdData == $past(spuQ))
        else $error("spurious vector lost");
    a_debug_keep:
        assert property (regRdStb && regAddr == OFS_DEBUG_CONTROL |=> regRdData == {30'h0, $past(dbgQ)})
        else $error("debug control readback wrong");
    a_lines_masked:
        assert property (dbgQ[1] |=> fastReqOutN && normalReqOutN)
        else $error("request line active under general mask");
    a_read_holds:
        assert property (!$past(regRdStb) |-> $stable(regRdData))
        else $error("read data changed without a read");
    // main scenarios
    cover property (regWrStb && regAddr == OFS_END_OF_SERVICE_COMMAND);
    cover property (!normalReqOutN);
    cover property (!fastReqOutN);
endmodule : vic_ctrl_assertions
bind vic_ctrl vic_ctrl_assertions vic_ctrl_assertions_inst (.clk_sys(clk_sys), .srst(srst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .srcReq(srcReq), .fastReqOutN(fastReqOutN),
    .normalReqOutN(normalReqOutN));
`default_nettype wire

// [verification/vic_core_model.sv]
// partner model: processor core sampling the two active-low request lines
`timescale 1ns/100ps
`default_nettype none
module vic_core_model
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // request lines from the controller
    input wire logic fastReqOutN,
    input wire logic normalReqOutN,
    // requests as the core sees them
    output var logic coreFiq,
    output var logic coreIrq
);
    // core registers the lines once, so a one-cycle glitch is still seen
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            coreFiq <= 1'b0;
            coreIrq <= 1'b0;
        end else begin
            coreFiq <= !fastReqOutN;
            coreIrq <= !normalReqOutN;
        end
    end
endmodule : vic_core_model
`default_nettype wire

// [verification/vic_ctrl_tb.sv]
// testbench: register and request line checks of the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module vic_ctrl_tb
    import vic_pkg::*;
;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [ADDR_W-1:0] regAddr = 12'h0;
    logic [DATA_W-1:0] regWrData = 32'h0;
    logic regWrStb = 1'b0;
    logic regRdStb = 1'b0;
    logic [NUM_SRC-1:0] srcReq = 32'h0;
    logic [DATA_W-1:0] regRdData;
    logic fastReqOutN;
    logic normalReqOutN;
    logic coreFiq;
    logic coreIrq;
    int failCount = 0;
    int testsRun = 0;
    localparam logic [11:0] RD_MAP [8] = '{OFS_CURRENT_SOURCE_NUMBER, OFS_PENDING_BITS,
        OFS_ENABLED_BITS, OFS_CORE_LINE_STATUS, OFS_SPURIOUS_VECTOR, OFS_DEBUG_CONTROL,
        OFS_FAST_FORCE_STATUS, 12'h118};
    // ========================================
    // design, core model and clock
    vic_ctrl vic_ctrl_inst (.clk_sys(clk_sys), .srst(srst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .srcReq(srcReq), .fastReqOutN(fastReqOutN),
        .normalReqOutN(normalReqOutN));
    vic_core_model vic_core_model_inst (.clk_sys(clk_sys), .srst(srst),
        .fastReqOutN(fastReqOutN), .normalReqOutN(normalReqOutN), .coreFiq(coreFiq),
        .coreIrq(coreIrq));
    always #5 clk_sys = ~clk_sys;
    // ========================================
    // access and compare tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            failCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge clk_sys);
        regWrStb <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge clk_sys);
        regRdStb <= 1'b0;
        #1 chk(regRdData, exp);
    endtask : rd
    // settle through the sync flops and the core's register, then compare
    task automatic lines(input logic f, input logic n);
        repeat (6) @(posedge clk_sys);
        chk({30'h0, coreFiq, coreIrq}, {30'h0, f, n});
    endtask : lines
    task automatic endSim();
        $display("checks %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : endSim
    // ========================================
    // watchdog, well above the few hundred cycles the tests need
    initial begin
        repeat (4000) @(posedge clk_sys);
        failCount++;
        endSim();
    end
    // ========================================
    // test sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        for (int i = 0; i < 8; i++) rd(RD_MAP[i], 32'h0);
        wr(OFS_ENABLE_COMMAND, 32'hf0f0_0005);
        wr(OFS_ENABLE_COMMAND, 32'h0000_0f00);
        wr(OFS_DISABLE_COMMAND, 32'h0000_0005);
        rd(OFS_ENABLED_BITS, 32'hf0f0_0f00);
        wr(OFS_DISABLE_COMMAND, 32'hffff_ffff);
        wr(OFS_SET_PENDING_COMMAND, 32'h8000_0003);
        rd(OFS_PENDING_BITS, 32'h8000_0003);
        wr(OFS_CLEAR_PENDING_COMMAND, 32'h8000_0001);
        rd(OFS_PENDING_BITS, 32'h0000_0002);
        wr(OFS_CLEAR_PENDING_COMMAND, 32'h0000_0002);
        @(posedge clk_sys);
        srcReq <= 32'h0000_0080;
        lines(1'b0, 1'b0);
        rd(OFS_PENDING_BITS, 32'h0000_0080);
        // source 7 at priority 5, source 9 at priority 6 raised by software
        wr(OFS_SPURIOUS_VECTOR, 32'h0000_5500);
        rd(OFS_SPURIOUS_VECTOR, 32'h0000_5500);
        wr(12'h09c, 32'h0000_7700);
        wr(12'h0a4, 32'h0000_9900);
        wr(12'h01c, 32'h0000_0005);
        wr(12'h024, 32'h0000_0006);
        wr(OFS_ENABLE_COMMAND, 32'h0000_0280);
        lines(1'b0, 1'b1);
        rd(OFS_CORE_LINE_STATUS, 32'h0000_0002);
        wr(OFS_SET_PENDING_COMMAND, 32'h0000_0200);
        rd(OFS_NORMAL_VECTOR_READ, 32'h0000_9900);
        rd(OFS_CURRENT_SOURCE_NUMBER, 32'h0000_0009);
        lines(1'b0, 1'b0);
        rd(OFS_NORMAL_VECTOR_READ, 32'h0000_5500);
        wr(OFS_CLEAR_PENDING_COMMAND, 32'h0000_0200);
        wr(OFS_END_OF_SERVICE_COMMAND, 32'hdead_beef);
        rd(OFS_CURRENT_SOURCE_NUMBER, 32'h0);
        lines(1'b0, 1'b1);
        rd(OFS_NORMAL_VECTOR_READ, 32'h0000_7700);
        rd(OFS_CURRENT_SOURCE_NUMBER, 32'h0000_0007);
        wr(OFS_END_OF_SERVICE_COMMAND, 32'h0);
        // protection mode: a read must not start service
        wr(OFS_DEBUG_CONTROL, 32'h0000_0001);
        rd(OFS_DEBUG_CONTROL, 32'h0000_0001);
        rd(OFS_NORMAL_VECTOR_READ, 32'h0000_7700);
        rd(OFS_CURRENT_SOURCE_NUMBER, 32'h0);
        wr(OFS_NORMAL_VECTOR_READ, 32'h0);
        rd(OFS_CURRENT_SOURCE_NUMBER, 32'h0000_0007);
        wr(OFS_END_OF_SERVICE_COMMAND, 32'h0000_0001);
        // general mask ties both lines inactive
        wr(OFS_DEBUG_CONTROL, 32'h0000_0002);
        lines(1'b0, 1'b0);
        rd(OFS_CORE_LINE_STATUS, 32'h0);
        wr(OFS_DEBUG_CONTROL, 32'h0);
        lines(1'b0, 1'b1);
        // fast forcing moves source 7 to the fast line
        wr(OFS_FAST_FORCE_ENABLE_COMMAND, 32'hffff_ffff);
        rd(OFS_FAST_FORCE_STATUS, 32'hffff_fffe);
        lines(1'b1, 1'b0);
        rd(OFS_CORE_LINE_STATUS, 32'h0000_0001);
        wr(OFS_FAST_FORCE_DISABLE_COMMAND, 32'h0000_0081);
        rd(OFS_FAST_FORCE_STATUS, 32'hffff_ff7e);
        lines(1'b0, 1'b1);
        // an edge source stays pending after its line drops
        wr(12'h00c, 32'h0000_0024);
        @(posedge clk_sys);
        srcReq <= 32'h0000_0088;
        lines(1'b0, 1'b1);
        srcReq <= 32'h0000_0080;
        rd(OFS_PENDING_BITS, 32'h0000_0088);
        wr(OFS_CLEAR_PENDING_COMMAND, 32'h0000_0008);
        rd(OFS_PENDING_BITS, 32'h0000_0080);
        // source 0 on the fast line, then a spurious fast read
        wr(OFS_VECT_BASE, 32'h0000_1100);
        wr(OFS_ENABLE_COMMAND, 32'h0000_0001);
        wr(OFS_SET_PENDING_COMMAND, 32'h0000_0001);
        lines(1'b1, 1'b1);
        rd(OFS_FAST_VECTOR_READ, 32'h0000_1100);
        rd(OFS_FAST_VECTOR_READ, 32'h0000_5500);
        lines(1'b0, 1'b1);
        endSim();
    end
endmodule : vic_ctrl_tb
`default_nettype wire
